// ===== core/awc_pkg.sv
// Package for the write and SMART command sequencer.
// Assumes a task-file front end that latches host register writes.
package awc_pkg;
  // Command codes
  localparam logic [7:0] CMD_WR_EXT = 8'h34;
  localparam logic [7:0] CMD_WR_NOERASE = 8'h38;
  localparam logic [7:0] CMD_WR_VERIFY = 8'h3c;
  localparam logic [7:0] CMD_WR_SECT0 = 8'h30;
  localparam logic [7:0] CMD_WR_SECT1 = 8'h31;
  localparam logic [7:0] CMD_SMART = 8'hb0;
  // SMART feature codes
  localparam logic [7:0] FEAT_READ_DATA = 8'hd0;
  localparam logic [7:0] FEAT_READ_THRESH = 8'hd1;
  localparam logic [7:0] FEAT_AUTOSAVE = 8'hd2;
  localparam logic [7:0] FEAT_ENABLE = 8'hd8;
  localparam logic [7:0] FEAT_DISABLE = 8'hd9;
  localparam logic [7:0] FEAT_STATUS = 8'hda;
  localparam logic [7:0] SMART_KEY_HI = 8'hc2;
  localparam logic [7:0] SMART_KEY_LO = 8'h4f;
  localparam logic [7:0] AUTOSAVE_ALT = 8'hf1;
  // Status bits
  localparam int ST_ERR = 0;
  localparam int ST_DRQ = 3;
  localparam int ST_RDY = 6;
  localparam int ST_BSY = 7;
  // Status byte values
  localparam logic [7:0] STAT_READY = 8'h40;
  localparam logic [7:0] STAT_BUSY = 8'h80;
  localparam logic [7:0] STAT_DATA = 8'h48;
  localparam logic [7:0] STAT_FAIL = 8'h41;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] ERR_WRITE = 8'h10;
  // Sector word count (256 x 16 bit)
  localparam int SECT_WORDS = 256;
  localparam logic [16:0] MAX_EXT = 17'h10000;
  localparam logic [16:0] MAX_STD = 17'h00100;

  // Task file as captured by the front end
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] feature;
    logic [15:0] count;   // high byte is the HOB copy
    logic [47:0] lba;     // ext: full; 28 bit: cyl/sector in [23:0], head in its own field
    logic [3:0] head;
  } awc_taskfile_t;

  // Request to the flash back end
  typedef struct packed {
    logic [47:0] lba;
    logic no_erase;
    logic verify;
  } awc_flash_req_t;
endpackage

// ===== core/awc_seq.sv
// Write and SMART command sequencer of the card task-file interface.
// Assumes a front end that latches task-file writes and a flash back end.
// How it works
// - Ext write moves 1 to 65536 sectors per the 16-bit count.
// - Ext count zero means 65536 sectors.
// - Ext write interrupts on each data block.
// - Write error stops at the failing sector.
// - Failing sector's full LBA is left in the address output.
// - Code 34h is the 48-bit address sector write.
// - Code 38h writes with no implied erase.
// - Non-erased target falls back to a normal write.
// - Code 3Ch verifies each sector after writing it.
// - SMART operation is picked by the feature value.
// - Unknown SMART features are aborted.
// - SMART on/off is kept in nonvolatile storage.
// - Features D8h/D9h with C2h/4Fh key switch SMART on/off.
// - Autosave feature completes with no other effect.
// - SMART read data returns exactly one sector.
// - Accept sets BSY, then DRQ with BSY clear, waits for data.
// - No interrupt before the first data block.
// - Eight-bit count zero means 256 sectors.
// - HOB bit selects the upper byte of extended fields.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module awc_seq
  import awc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cmd_go_in,
  input wire awc_pkg::awc_taskfile_t tf_in,
  input wire logic host_word_in,
  input wire logic smart_nv_in,
  input wire logic flash_done_in,
  input wire logic flash_err_in,
  input wire logic flash_erased_in,
  input wire logic verify_ok_in,
  output logic [7:0] status_out,
  output logic [7:0] error_out,
  output logic irq_out,
  output logic [47:0] err_lba_out,
  output logic [16:0] remain_out,
  output logic flash_go_out,
  output awc_pkg::awc_flash_req_t flash_req_out,
  output logic smart_rd_out,
  output logic smart_en_out,
  output logic nv_wr_out,
  output logic send_word_out
);
  import awc_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ACCEPT = 7'b0000010,
    S_FILL = 7'b0000100,
    S_PROG = 7'b0001000,
    S_SEND = 7'b0010000,
    S_DONE = 7'b0100000,
    S_FAIL = 7'b1000000
  } awc_state_t;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  awc_state_t state_reg;
  logic [16:0] left_reg;
  logic [47:0] lba_reg;
  logic [8:0] word_reg;
  logic ext_reg, noerase_reg, verify_reg, smart_reg, nv_reg;
  // Abort rather than write error for a command that never ran
  logic abort_reg;
  // High once the stored SMART state has been taken after reset
  logic nv_loaded_reg;
  // No-erase request bit held in a flop for the back end
  logic no_erase_reg;
  logic [7:0] status_reg, error_reg;
  logic irq_reg, go_reg, rd_reg, nvw_reg, send_reg;

  // Reset release through two flops
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  // Only the second flop feeds the logic
  assign rst_n = rst_sync_reg[1];

  // Command decode
  // ext code
  wire is_ext = (tf_in.cmd == CMD_WR_EXT);
  wire is_noerase = (tf_in.cmd == CMD_WR_NOERASE);
  wire is_verify = (tf_in.cmd == CMD_WR_VERIFY);
  wire is_write = is_ext || is_noerase || is_verify
    || tf_in.cmd == CMD_WR_SECT0 || tf_in.cmd == CMD_WR_SECT1;
  wire is_smart = (tf_in.cmd == CMD_SMART);
  wire key_ok = tf_in.lba[23:16] == SMART_KEY_HI
    && tf_in.lba[15:8] == SMART_KEY_LO;
  wire f_read = tf_in.feature == FEAT_READ_DATA
    || tf_in.feature == FEAT_READ_THRESH;
  wire f_auto = tf_in.feature == FEAT_AUTOSAVE
    && (tf_in.count[7:0] == 8'h00 || tf_in.count[7:0] == AUTOSAVE_ALT);
  wire f_en = tf_in.feature == FEAT_ENABLE;
  wire f_dis = tf_in.feature == FEAT_DISABLE;
  wire f_stat = tf_in.feature == FEAT_STATUS;
  wire smart_ok = key_ok && (f_read || f_auto || f_en || f_dis || f_stat);
  // ext 16-bit count, zero is 65536; 8-bit count, zero is 256
  wire [16:0] cnt_ext = (tf_in.count == 16'h0000) ? MAX_EXT
    : {1'b0, tf_in.count};
  wire [16:0] cnt_std = (tf_in.count[7:0] == 8'h00) ? MAX_STD
    : {9'h000, tf_in.count[7:0]};
  // 28-bit address from head, cylinder and sector number
  wire [47:0] lba28 = {20'h00000, tf_in.head, tf_in.lba[23:0]};
  wire last_word = (word_reg == 9'(SECT_WORDS - 1));
  wire [47:0] lba_inc = lba_reg + 48'h1;
  // a flash error or a failed verify ends the command here
  wire sect_bad = flash_err_in || (verify_reg && !verify_ok_in);

  // Sequencer state
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= S_IDLE;
    else
    begin
      unique case (state_reg)
        S_IDLE:
          if (cmd_go_in)
            state_reg <= (is_write || (is_smart && smart_ok)) ? S_ACCEPT
              : S_FAIL;
        S_ACCEPT:
          state_reg <= smart_reg ? (rd_reg ? S_SEND : S_DONE) : S_FILL;
        S_FILL:
          if (host_word_in && last_word)
            state_reg <= S_PROG;
        S_PROG:
          if (flash_done_in)
            state_reg <= sect_bad ? S_FAIL
              : (left_reg == 17'h00001 ? S_DONE : S_FILL);
        S_SEND:
          if (last_word)
            state_reg <= S_DONE;
        S_DONE:
          state_reg <= S_IDLE;
        S_FAIL:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // Command parameters, counters and address
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_reg <= 17'h0;
      lba_reg <= 48'h0;
      word_reg <= 9'h0;
      ext_reg <= 1'b0;
      noerase_reg <= 1'b0;
      verify_reg <= 1'b0;
      smart_reg <= 1'b0;
      rd_reg <= 1'b0;
      abort_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == S_IDLE && cmd_go_in)
      begin
        // count and LBA arrive with HOB bytes already merged
        left_reg <= is_ext ? cnt_ext : cnt_std;
        lba_reg <= is_ext ? tf_in.lba : lba28;
        ext_reg <= is_ext;
        noerase_reg <= is_noerase;
        verify_reg <= is_verify;
        smart_reg <= is_smart;
        rd_reg <= is_smart && f_read;
        // anything but a write that fails at once is an abort
        abort_reg <= !is_write;
      end
      // Word counter wraps at the end of each sector
      if ((state_reg == S_FILL && host_word_in) || state_reg == S_SEND)
        word_reg <= last_word ? 9'h0 : word_reg + 9'h1;
      if (state_reg == S_PROG && flash_done_in && !sect_bad)
      begin
        left_reg <= left_reg - 17'h1;
        lba_reg <= lba_inc;
      end
    end
  end

  // Host-visible status, error and interrupt
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_reg <= STAT_READY;
      error_reg <= 8'h0;
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= 1'b0;
      unique case (state_reg)
        S_IDLE:
          if (cmd_go_in)
          begin
            status_reg <= STAT_BUSY;
            error_reg <= 8'h0;
          end
        // DRQ set, BSY cleared, except SMART without read stays busy; no first interrupt
        S_ACCEPT:
          status_reg <= smart_reg && !rd_reg ? STAT_BUSY : STAT_DATA;
        S_FILL:
          if (host_word_in && last_word)
            status_reg <= STAT_BUSY;
        S_PROG:
          if (flash_done_in && !sect_bad && left_reg != 17'h00001)
          begin
            status_reg <= STAT_DATA;
            irq_reg <= 1'b1;
          end
        S_SEND:
          if (last_word)
            status_reg <= STAT_BUSY;
        S_DONE:
        begin
          status_reg <= STAT_READY;
          irq_reg <= 1'b1;
        end
        // Commands that never ran abort; sector failures are write errors
        S_FAIL:
        begin
          status_reg <= STAT_FAIL;
          error_reg <= abort_reg ? ERR_ABORT : ERR_WRITE;
          irq_reg <= 1'b1;
        end
      endcase
    end
  end

  // Flash requests, SMART state and data send strobes
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      go_reg <= 1'b0;
      nv_reg <= 1'b0;
      nv_loaded_reg <= 1'b0;
      nvw_reg <= 1'b0;
      send_reg <= 1'b0;
      no_erase_reg <= 1'b0;
    end
    else
    begin
      go_reg <= state_reg == S_FILL && host_word_in && last_word;
      send_reg <= state_reg == S_SEND;
      nvw_reg <= 1'b0;
      // skip erase; a sector not erased gets a normal write
      no_erase_reg <= noerase_reg & flash_erased_in;
      // take the stored SMART state once, at the first edge
      nv_loaded_reg <= 1'b1;
      if (!nv_loaded_reg)
        nv_reg <= smart_nv_in;
      if (state_reg == S_IDLE && cmd_go_in && is_smart && key_ok
          && (f_en || f_dis))
      begin
        nv_reg <= f_en;
        nvw_reg <= 1'b1;
      end
    end
  end

  assign status_out = status_reg;
  assign error_out = error_reg;
  assign irq_out = irq_reg;
  assign err_lba_out = lba_reg;
  assign remain_out = left_reg;
  assign flash_go_out = go_reg;
  // Request fields all come from flops
  assign flash_req_out = '{lba: lba_reg,
    no_erase: no_erase_reg, verify: verify_reg};
  assign smart_rd_out = rd_reg;
  assign smart_en_out = nv_reg;
  assign nv_wr_out = nvw_reg;
  assign send_word_out = send_reg;
endmodule
`default_nettype wire

// ===== verification/awc_host.sv
// Host controller model that writes sector words while DRQ stands.
// Assumes the sequencer status byte and one shared clock.
`timescale 1ns/1ps
`default_nettype none
module awc_host
  import awc_pkg::*;
(
  input wire logic clock_in,
  input wire logic [7:0] status_in,
  input wire logic en_in,
  input wire logic slow_in,
  output logic word_out
);
  initial word_out = 1'b0;
  // words only with DRQ and BSY clear
  always
  begin
    @(posedge clock_in);
    if (en_in && status_in[ST_DRQ] && !status_in[ST_BSY])
    begin
      for (int i = 0; i < SECT_WORDS; i++)
      begin
        word_out <= 1'b1;
        @(posedge clock_in);
        if (slow_in)
        begin
          word_out <= 1'b0;
          @(posedge clock_in);
        end
      end
      word_out <= 1'b0;
      // Quiet until the card turns busy again
      while (!status_in[ST_BSY])
        @(posedge clock_in);
    end
  end
endmodule
`default_nettype wire

// ===== verification/awc_seq_chk.sv
// Checker for the write and SMART sequencer, bound to its ports.
// Assumes one clock domain and the status layout of the package.
`timescale 1ns/1ps
`default_nettype none
module awc_seq_chk
  import awc_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cmd_go_in,
  input wire awc_pkg::awc_taskfile_t tf_in,
  input wire logic flash_done_in,
  input wire logic flash_err_in,
  input wire logic [7:0] status_out,
  input wire logic [7:0] error_out,
  input wire logic irq_out,
  input wire logic [16:0] remain_out
);
  // Commands seen while BSY is clear, split by kind
  wire take_w = cmd_go_in && !status_out[ST_BSY];
  wire ext_w = take_w && tf_in.cmd == CMD_WR_EXT;
  wire bad_w = take_w && tf_in.cmd == CMD_SMART &&
    !(tf_in.feature inside {FEAT_READ_DATA, FEAT_READ_THRESH,
    FEAT_AUTOSAVE, FEAT_ENABLE, FEAT_DISABLE, FEAT_STATUS});
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_bsy_take: assert property (
    take_w |=> status_out[ST_BSY]) else $error("busy not set");
  a_drq_write: assert property (
    ext_w |-> ##2 (status_out[ST_DRQ] && !status_out[ST_BSY]))
    else $error("data request late");
  a_first_quiet: assert property (
    ext_w |=> !irq_out [*2]) else $error("early interrupt");
  a_ext_zero: assert property (
    ext_w && tf_in.count == 16'h0000 |-> ##2 remain_out == MAX_EXT)
    else $error("zero count not max");
  a_std_zero: assert property (
    take_w && tf_in.cmd == CMD_WR_SECT1 && tf_in.count[7:0] == 8'h00
    |-> ##2 remain_out == MAX_STD) else $error("zero count not 256");
  a_abort_bad: assert property (
    bad_w |-> ##[1:4] (status_out[ST_ERR] && error_out == ERR_ABORT))
    else $error("bad feature not aborted");
  a_err_stop: assert property (
    flash_done_in && flash_err_in && status_out[ST_BSY]
    |-> ##[1:3] (status_out[ST_ERR] && !status_out[ST_DRQ]))
    else $error("write went on after error");
  a_done_irq: assert property (
    flash_done_in && status_out[ST_BSY] |-> ##[1:3] irq_out)
    else $error("no interrupt after sector");
endmodule
`default_nettype wire

// ===== verification/test_awc_seq.sv
// Bench for the write and SMART sequencer with a host model.
// Assumes the package, sequencer, checker and host model compile first.
`timescale 1ns/1ps
`default_nettype none
module test_awc_seq;
  import awc_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cmd_go_in = 1'b0;
  logic smart_nv_in = 1'b0;
  logic flash_done_in = 1'b0;
  logic flash_err_in = 1'b0;
  logic flash_erased_in = 1'b1;
  logic verify_ok_in = 1'b1;
  logic hen = 1'b0;
  logic slow = 1'b0;
  logic host_word_in, irq_out, flash_go_out, smart_rd_out, smart_en_out;
  logic nv_wr_out, send_word_out;
  logic [7:0] status_out, error_out;
  logic [47:0] err_lba_out;
  logic [16:0] remain_out;
  awc_taskfile_t tf_in = '0;
  awc_flash_req_t flash_req_out;
  int n_mismatch = 0;
  int n_checks = 0;
  int nirq = 0;
  int nsend = 0;
  int nnv = 0;
  // Clock and event counters
  always #2 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    nirq += (irq_out === 1'b1);
    nsend += (send_word_out === 1'b1);
    nnv += (nv_wr_out === 1'b1);
  end
  awc_seq u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .cmd_go_in(cmd_go_in), .tf_in(tf_in), .host_word_in(host_word_in),
    .smart_nv_in(smart_nv_in), .flash_done_in(flash_done_in),
    .flash_err_in(flash_err_in), .flash_erased_in(flash_erased_in),
    .verify_ok_in(verify_ok_in), .status_out(status_out),
    .error_out(error_out), .irq_out(irq_out), .err_lba_out(err_lba_out),
    .remain_out(remain_out), .flash_go_out(flash_go_out),
    .flash_req_out(flash_req_out), .smart_rd_out(smart_rd_out),
    .smart_en_out(smart_en_out), .nv_wr_out(nv_wr_out),
    .send_word_out(send_word_out));
  awc_host u_host (.clock_in(clock_in), .status_in(status_out),
    .en_in(hen), .slow_in(slow), .word_out(host_word_in));
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task rst;
    rst_n_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
  endtask
  task issue(input logic [7:0] c, input logic [7:0] f,
    input logic [15:0] n, input logic [47:0] a);
    @(posedge clock_in);
    tf_in <= '{c, f, n, a, a[27:24]};
    cmd_go_in <= 1'b1;
    @(posedge clock_in);
    cmd_go_in <= 1'b0;
  endtask
  // Bounded wait for a flash request or for the card to go idle
  task wt(input bit go);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      #1;
      if (go ? flash_go_out === 1'b1 : status_out[7:3] === 5'h08) break;
      @(posedge clock_in);
    end
    if (i == 3000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  endtask
  task done(input logic e, input logic v);
    @(posedge clock_in);
    flash_done_in <= 1'b1;
    flash_err_in <= e;
    verify_ok_in <= v;
    @(posedge clock_in);
    flash_done_in <= 1'b0;
    flash_err_in <= 1'b0;
    verify_ok_in <= 1'b1;
  endtask
  // Sector write, failing at sector bad when bad is below n
  task t_wr(input logic [7:0] c, input logic [15:0] n,
    input logic [47:0] a, input int bad, input logic [1:0] fl);
    nirq = 0;
    hen <= 1'b1;
    issue(c, 8'h00, n, a);
    repeat (2) @(posedge clock_in);
    #1;
    chk(remain_out, n);
    for (int s = 0; s < n && s <= bad; s++)
    begin
      wt(1);
      chk(flash_req_out.lba, a + s);
      chk({flash_req_out.no_erase, flash_req_out.verify}, fl);
      done(s == bad && c != CMD_WR_VERIFY, !(s == bad && c == CMD_WR_VERIFY));
    end
    wt(0);
    hen <= 1'b0;
    // The closing interrupt is counted one edge later
    @(posedge clock_in);
    #1;
    chk(status_out, bad < n ? 8'h41 : 8'h40);
    if (bad < n)
    begin
      chk(error_out, ERR_WRITE);
      chk(err_lba_out, a + bad);
    end
    chk(nirq, bad < n ? bad + 1 : n);
    $display("write %h done", c);
  endtask
  task t_cnt(input logic [7:0] c, input logic [15:0] n,
    input logic [16:0] e);
    rst;
    issue(c, 8'h00, n, 48'h0);
    repeat (2) @(posedge clock_in);
    #1;
    chk(remain_out, e);
    $display("count %h done", n);
  endtask
  // SMART features in turn, then a bad feature, a bad key and a good enable
  task t_smart;
    logic [7:0] fl [8] = '{FEAT_READ_DATA, FEAT_READ_THRESH, FEAT_STATUS,
      FEAT_AUTOSAVE, FEAT_DISABLE, 8'h55, FEAT_ENABLE, FEAT_ENABLE};
    smart_nv_in <= 1'b1;
    rst;
    // Host stays off: SMART data flows to the host, not from it
    hen <= 1'b0;
    nnv = 0;
    #1;
    chk(smart_en_out, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      nsend = 0;
      issue(CMD_SMART, fl[i], 16'h00f1, i == 6 ? 48'h0 : 48'hc24f00);
      #1;
      chk(smart_rd_out, i < 2);
      wt(0);
      chk(status_out[ST_ERR], i == 5 || i == 6);
      if (i == 0)
        chk(nsend, SECT_WORDS);
      if (i == 4)
        chk(smart_en_out, 1'b0);
    end
    chk(smart_en_out, 1'b1);
    chk(nnv, 2);
    $display("smart done");
  endtask
  // Main sequence and overall watchdog
  initial
  begin
    rst;
    t_wr(CMD_WR_EXT, 16'd2, 48'h8765_4321_00fe, 99, 2'b00);
    slow <= 1'b1;
    t_wr(CMD_WR_NOERASE, 16'd2, 48'h0abc_def0, 99, 2'b10);
    slow <= 1'b0;
    flash_erased_in <= 1'b0;
    t_wr(CMD_WR_NOERASE, 16'd1, 48'h0000_0010, 99, 2'b00);
    flash_erased_in <= 1'b1;
    t_wr(CMD_WR_VERIFY, 16'd3, 48'h0123_4567, 1, 2'b01);
    t_wr(CMD_WR_EXT, 16'd3, 48'hffff_0000_0000, 2, 2'b00);
    t_wr(CMD_WR_SECT0, 16'd1, 48'h0765_4321, 99, 2'b00);
    t_cnt(CMD_WR_EXT, 16'h0000, MAX_EXT);
    t_cnt(CMD_WR_SECT1, 16'h0000, MAX_STD);
    t_cnt(CMD_WR_EXT, 16'hffff, 17'h0ffff);
    t_smart;
    report_and_stop;
  end
  initial
  begin
    repeat (90000) @(posedge clock_in);
    n_mismatch++;
    report_and_stop;
  end
endmodule
bind awc_seq awc_seq_chk u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .cmd_go_in(cmd_go_in), .tf_in(tf_in), .flash_done_in(flash_done_in),
  .flash_err_in(flash_err_in), .status_out(status_out),
  .error_out(error_out), .irq_out(irq_out), .remain_out(remain_out));
`default_nettype wire
